/* File: core/pmc_power_mode_controller.sv */
// Functional notes
// - Throttled CPU runs one instruction cycle per N; ratio code 001 gives 1:4.
// - Peripheral phase clocks keep running every cycle while throttled.
// - Throttling leaves band gap and system oscillators running.
// - Interrupt in throttle: multicycle instruction completes before vector 0x0004 fetch.
// - Prefetch clearing global enable: no ISR, throttle still cleared, full speed.
// - Halt enters Sleep with idle_select clear, Idle with it set.
// - Sleep entry clears watchdog, keeps it counting if enabled, stops CPU clock.
// - Sleep entry clears power_down_flag and sets timeout_flag.
// - Sleep keeps enabled low-speed/internal oscillators running; port drives hold.
// - Non-watchdog resets act in Sleep as when awake.
// - Resets wake by resetting; any interrupt except clock switch continues execution.
// - Wake needs peripheral enable bit, independent of global enable.
// - After wake run next instruction, then vector if global enable set.
// - Halt prefetches the instruction at PC + 2.
// - Wake clears watchdog and waits for memory, clock and brown-out ready.
// - Enabled interrupt pending before halt, globals off: halt is a no-op.
// - Interrupt during or after halt: complete halt, wake, clear watchdog, flags set.
// - Crystal mode wake inserts 1024-period start-up delay; other modes skip it.
// - Idle halts CPU and memory but peripheral and system clocks run.
// - Enabled interrupt ends Idle, idle_select unchanged; later halt re-enters Idle.
// - Recover-on-irq with throttling: Idle-ending interrupt restores full speed.
// - Watchdog in Idle wakes instead of resetting; throttle enable untouched.
// - ISR entry clears throttle enable when recover_on_irq is set.
// - ISR return sets throttle enable when rethrottle_on_return is set.
// - Ratio codes 000 to 111 map to 1:2 doubling up to 1:256.
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/100ps
module pmc_power_mode_controller
  import pmc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core fetch and interrupt interface
  input wire logic halt_exec,
  input wire logic [15:0] halt_pc,
  input wire logic instr_busy,
  input wire logic isr_enter,
  input wire logic isr_return,
  input wire logic global_irq_enable,
  input wire logic [7:0] irq_flags,
  input wire logic [7:0] peripheral_irq_enable,
  input wire logic [7:0] clk_switch_irq_mask,
  // Readiness and watchdog
  input wire logic program_memory_ready,
  input wire logic sys_clock_ready,
  input wire logic brownout_ready,
  input wire logic watchdog_expired,
  // Core and clock controls
  output logic cpu_cycle_en,
  output logic periph_clk_en,
  output logic osc_run_en,
  output logic port_hold,
  output logic watchdog_clear,
  output logic watchdog_run,
  output logic watchdog_reset_req,
  output logic vector_req,
  output logic [15:0] fetch_addr,
  output logic power_down_flag,
  output logic timeout_flag
);
  import pmc_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] ctrl_q;
  logic [2:0] cfg_q;
  logic pd_q, to_q;
  pmc_state_t state_q;
  logic [7:0] thr_cnt_q;
  logic [10:0] ost_cnt_q;
  logic wdclr_q;
  logic vec_pend_q;
  logic [15:0] fetch_q;

  // Terminal count for ratio code: 2 << code, minus one
  function automatic logic [7:0] pmc_ratio_last(input logic [2:0] code);
    logic [8:0] r;
    r = 9'h002 << code;
    return 8'(r - 9'h001);
  endfunction : pmc_ratio_last

  wire logic cpu_throttle_enable = ctrl_q[PMC_THR_BIT];
  wire logic recover_on_irq = ctrl_q[PMC_ROI_BIT];
  wire logic rethrottle_on_return = ctrl_q[PMC_REOR_BIT];
  wire logic idle_select = ctrl_q[PMC_IDLE_BIT];
  wire logic [2:0] ratio = ctrl_q[PMC_RATIO_LSB +: 3];

  // Wake sources exclude the clock switch interrupt and ignore global enable
  logic wake_irq;
  assign wake_irq = |(irq_flags & peripheral_irq_enable & ~clk_switch_irq_mask);

  ////////////////////////////////////////////////////////////////////
  // APB access; always zero wait states
  logic wr_acc;
  assign wr_acc = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Unmapped addresses read zero, writes ignored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        PMC_CTRL_OFS: prdata <= {24'h00_0000, ctrl_q};
        PMC_STAT_OFS: prdata <= {25'h000_0000, state_q, 2'b00, to_q, pd_q};
        PMC_CFG_OFS: prdata <= {29'h0000_0000, cfg_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control register: hardware set/clear of throttle enable wins over software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= PMC_CTRL_RST;
    else
    begin
      if (wr_acc && paddr == PMC_CTRL_OFS)
        ctrl_q <= {pwdata[7:4], 1'b0, pwdata[2:0]};
      if (isr_enter && recover_on_irq)
        ctrl_q[PMC_THR_BIT] <= 1'b0;
      else if (state_q == PMC_IDLE && wake_irq && recover_on_irq)
        ctrl_q[PMC_THR_BIT] <= 1'b0;
      // Vector dropped by a cleared global enable still ends throttling
      else if (vec_pend_q && state_q == PMC_RUN && !global_irq_enable && recover_on_irq)
        ctrl_q[PMC_THR_BIT] <= 1'b0;
      else if (isr_return && rethrottle_on_return)
        ctrl_q[PMC_THR_BIT] <= 1'b1;
    end
  end

  // Configuration: crystal mode, brown-out enable, watchdog in Sleep
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_q <= PMC_CFG_RST;
    else if (wr_acc && paddr == PMC_CFG_OFS)
      cfg_q <= pwdata[2:0];
  end

  ////////////////////////////////////////////////////////////////////
  // Power state machine
  logic halt_go;
  assign halt_go = halt_exec && state_q == PMC_RUN && !(wake_irq && !global_irq_enable);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= PMC_RUN;
    else
    begin
      case (state_q)
        PMC_RUN:
          if (halt_go)
            state_q <= idle_select ? PMC_IDLE : PMC_SLEEP;
        PMC_SLEEP:
          if (wake_irq)
            state_q <= cfg_q[PMC_XTAL_BIT] ? PMC_WAKE_OST : PMC_WAKE_RDY;
        PMC_IDLE:
          if (wake_irq || watchdog_expired)
            state_q <= PMC_RUN;
        PMC_WAKE_OST:
          if (ost_cnt_q == PMC_OST_CYC - 11'd1)
            state_q <= PMC_WAKE_RDY;
        PMC_WAKE_RDY:
          if (program_memory_ready && sys_clock_ready
              && (brownout_ready || !cfg_q[PMC_BOREN_BIT]))
            state_q <= PMC_RUN;
        default: state_q <= PMC_RUN;
      endcase
    end
  end

  // Start-up delay counter, one period per clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ost_cnt_q <= 11'd0;
    else if (state_q == PMC_WAKE_OST)
      ost_cnt_q <= ost_cnt_q + 11'd1;
    else
      ost_cnt_q <= 11'd0;
  end

  ////////////////////////////////////////////////////////////////////
  // Status flags; no-op halt leaves them alone
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pd_q <= 1'b1;
      to_q <= 1'b1;
    end
    else if (halt_go && !idle_select)
    begin
      pd_q <= 1'b0;
      to_q <= 1'b1;
    end
  end

  // Watchdog clear on Sleep entry and on wake; held high through the start-up delay
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wdclr_q <= 1'b0;
    else
      wdclr_q <= (halt_go && !idle_select)
                 || (state_q == PMC_SLEEP && wake_irq)
                 || state_q == PMC_WAKE_OST;
  end

  ////////////////////////////////////////////////////////////////////
  // Throttle counter; peripherals never see it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      thr_cnt_q <= 8'h00;
    else if (!cpu_throttle_enable || thr_cnt_q == pmc_ratio_last(ratio))
      thr_cnt_q <= 8'h00;
    else
      thr_cnt_q <= thr_cnt_q + 8'h01;
  end

  // Vector request: wait for next instruction after wake, and multicycle end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vec_pend_q <= 1'b0;
    else if (vector_req)
      vec_pend_q <= 1'b0;
    else if ((state_q == PMC_WAKE_RDY || state_q == PMC_IDLE) && wake_irq)
      vec_pend_q <= 1'b1;
    // Wake that finds global enable clear runs on in line; no late vector
    else if (state_q == PMC_RUN && !global_irq_enable)
      vec_pend_q <= 1'b0;
  end

  // Fetch address: halt prefetches next word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fetch_q <= 16'h0000;
    else if (vector_req)
      fetch_q <= PMC_VECTOR;
    else if (halt_exec && state_q == PMC_RUN)
      fetch_q <= halt_pc + PMC_PC_STEP;
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign cpu_cycle_en = state_q == PMC_RUN
                        && (!cpu_throttle_enable || thr_cnt_q == 8'h00);
  assign periph_clk_en = state_q != PMC_SLEEP && state_q != PMC_WAKE_OST;
  assign osc_run_en = 1'b1;
  assign port_hold = state_q != PMC_RUN;
  assign watchdog_clear = wdclr_q;
  assign watchdog_run = state_q != PMC_SLEEP || cfg_q[PMC_WDSLP_BIT];
  assign watchdog_reset_req = watchdog_expired && state_q != PMC_IDLE;
  assign vector_req = vec_pend_q && global_irq_enable && state_q == PMC_RUN
                      && !instr_busy && cpu_cycle_en;
  assign fetch_addr = fetch_q;
  assign power_down_flag = pd_q;
  assign timeout_flag = to_q;

  ////////////////////////////////////////////////////////////////////
  // Assertions
  property p_sleep_entry;
    @(posedge pclk) disable iff (!presetn)
      halt_go && !idle_select |=> state_q == PMC_SLEEP && !pd_q && to_q && wdclr_q;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("bad sleep entry");

  property p_idle_entry;
    @(posedge pclk) disable iff (!presetn)
      halt_go && idle_select |=> state_q == PMC_IDLE && $stable(pd_q);
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("bad idle entry");

  property p_noop_halt;
    @(posedge pclk) disable iff (!presetn)
      state_q == PMC_RUN && halt_exec && wake_irq && !global_irq_enable
      |=> state_q == PMC_RUN && $stable(pd_q) && !wdclr_q;
  endproperty
  a_noop_halt: assert property (p_noop_halt) else $error("halt not a no-op");

  property p_idle_wd;
    @(posedge pclk) disable iff (!presetn)
      state_q == PMC_IDLE && watchdog_expired && !wake_irq
      |-> !watchdog_reset_req ##1 state_q == PMC_RUN && $stable(cpu_throttle_enable);
  endproperty
  a_idle_wd: assert property (p_idle_wd) else $error("idle watchdog misbehaved");

  property p_roi;
    @(posedge pclk) disable iff (!presetn)
      isr_enter && recover_on_irq |=> !cpu_throttle_enable;
  endproperty
  a_roi: assert property (p_roi) else $error("throttle not cleared");

  property p_ratio4;
    @(posedge pclk) disable iff (!presetn)
      cpu_throttle_enable && ratio == 3'b001 && state_q == PMC_RUN && cpu_cycle_en
      && !isr_enter && !wr_acc
      |=> !cpu_cycle_en [*3];
  endproperty
  a_ratio4: assert property (p_ratio4) else $error("ratio 1:4 broken");

  property p_ost;
    @(posedge pclk) disable iff (!presetn)
      $rose(state_q == PMC_WAKE_OST) |-> state_q == PMC_WAKE_OST [*8];
  endproperty
  a_ost: assert property (p_ost) else $error("start-up delay cut short");

  property p_ready;
    @(posedge pclk) disable iff (!presetn)
      state_q == PMC_WAKE_RDY && !program_memory_ready |=> state_q == PMC_WAKE_RDY;
  endproperty
  a_ready: assert property (p_ready) else $error("resumed before ready");

  property p_prefetch;
    @(posedge pclk) disable iff (!presetn)
      halt_exec && state_q == PMC_RUN && !vector_req |=> fetch_addr == $past(halt_pc) + 16'h0002;
  endproperty
  a_prefetch: assert property (p_prefetch) else $error("bad prefetch");

  // Wake bookkeeping, rethrottle on ISR return and Sleep outputs
  property p_wake_flags;
    @(posedge pclk) disable iff (!presetn)
      state_q == PMC_SLEEP && wake_irq |=> state_q != PMC_SLEEP && wdclr_q && !pd_q && to_q;
  endproperty
  a_wake_flags: assert property (p_wake_flags) else $error("bad wake from sleep");

  property p_inline;
    @(posedge pclk) disable iff (!presetn)
      state_q == PMC_RUN && !global_irq_enable |=> !vec_pend_q;
  endproperty
  a_inline: assert property (p_inline) else $error("vector kept without enable");

  property p_idle_keep;
    @(posedge pclk) disable iff (!presetn)
      state_q == PMC_IDLE && wake_irq && !wr_acc |=> state_q == PMC_RUN && $stable(idle_select);
  endproperty
  a_idle_keep: assert property (p_idle_keep) else $error("idle exit changed select");

  property p_rethrottle;
    @(posedge pclk) disable iff (!presetn)
      isr_return && rethrottle_on_return && !isr_enter && state_q == PMC_RUN && !vec_pend_q
      |=> cpu_throttle_enable;
  endproperty
  a_rethrottle: assert property (p_rethrottle) else $error("throttle not restored");

  property p_sleep_quiet;
    @(posedge pclk) disable iff (!presetn)
      state_q == PMC_SLEEP
      |-> !cpu_cycle_en && port_hold && osc_run_en && watchdog_run == cfg_q[PMC_WDSLP_BIT];
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("sleep outputs wrong");

  c_sleep_wake: cover property (@(posedge pclk) state_q == PMC_SLEEP ##[1:20] state_q == PMC_RUN);
  c_idle_wake: cover property (@(posedge pclk) state_q == PMC_IDLE ##1 state_q == PMC_RUN);
  c_vector: cover property (@(posedge pclk) vector_req);
  c_busy_hold: cover property (@(posedge pclk) vec_pend_q && instr_busy ##[1:8] vector_req);

endmodule : pmc_power_mode_controller

/* File: core/pmc_pkg.sv */
package pmc_pkg;

  // Register map, byte addresses on the APB side
  localparam logic [11:0] PMC_CTRL_OFS = 12'h0000;
  localparam logic [11:0] PMC_STAT_OFS = 12'h0004;
  localparam logic [11:0] PMC_CFG_OFS = 12'h0008;

  // Control register fields
  localparam int PMC_RATIO_LSB = 0;
  localparam int PMC_REOR_BIT = 4;
  localparam int PMC_ROI_BIT = 5;
  localparam int PMC_THR_BIT = 6;
  localparam int PMC_IDLE_BIT = 7;
  localparam logic [7:0] PMC_CTRL_RST = 8'h00;

  // Status register fields
  localparam int PMC_PD_BIT = 0;
  localparam int PMC_TO_BIT = 1;
  localparam int PMC_MODE_LSB = 4;

  // Configuration register fields
  localparam int PMC_XTAL_BIT = 0;
  localparam int PMC_BOREN_BIT = 1;
  localparam int PMC_WDSLP_BIT = 2;
  localparam logic [2:0] PMC_CFG_RST = 3'h0;

  // Oscillator start-up delay, counted in oscillator periods
  localparam int PMC_OST_PERIODS = 1024;
  localparam logic [10:0] PMC_OST_CYC = 11'(PMC_OST_PERIODS);

  // Interrupt vector
  localparam logic [15:0] PMC_VECTOR = 16'h0004;
  localparam logic [15:0] PMC_PC_STEP = 16'h0002;

  // Power state
  typedef enum logic [2:0] {
    PMC_RUN = 3'b000,
    PMC_SLEEP = 3'b001,
    PMC_IDLE = 3'b010,
    PMC_WAKE_OST = 3'b011,
    PMC_WAKE_RDY = 3'b100
  } pmc_state_t;

endpackage : pmc_pkg

/* File: verification/pmc_core_model.sv */
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////
// Core stand-in: halt pulses, ISR entry and return, global enable
module pmc_core_model
(
  // Clock
  input wire logic pclk,
  // From controller
  input wire logic vector_req,
  // To controller
  output logic halt_exec,
  output logic [15:0] halt_pc,
  output logic instr_busy,
  output logic isr_enter,
  output logic isr_return,
  output logic global_irq_enable
);
  // Idle levels; a stale pc is never left on the bus
  initial
  begin
    halt_exec = 1'b0;
    halt_pc = 16'hffff;
    instr_busy = 1'b0;
    isr_enter = 1'b0;
    isr_return = 1'b0;
    global_irq_enable = 1'b0;
  end

  // A vector fetch is followed by ISR entry on the next cycle
  always @(posedge pclk)
  begin
    isr_enter <= vector_req;
  end

  // Halt instruction for one cycle, then pc inverted
  task automatic halt(input logic [15:0] pc);
    @(posedge pclk);
    halt_exec <= 1'b1;
    halt_pc <= pc;
    @(posedge pclk);
    halt_exec <= 1'b0;
    halt_pc <= ~pc;
  endtask : halt

  // Return from the service routine
  task automatic ret();
    @(posedge pclk);
    isr_return <= 1'b1;
    @(posedge pclk);
    isr_return <= 1'b0;
  endtask : ret
endmodule : pmc_core_model

/* File: verification/tb.sv */
`timescale 1ns/100ps
module tb;
  import pmc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [7:0] irq_flags = 8'h00;
  logic mem_rdy = 1'b1;
  logic wdx = 1'b0;
  logic [7:0] irq_en = 8'h03;
  logic osc_run_en, watchdog_run, power_down_flag, timeout_flag;
  logic [31:0] prdata;
  logic [15:0] fetch_addr;
  logic [15:0] halt_pc;
  logic pready, cpu_cycle_en, periph_clk_en, port_hold, watchdog_clear;
  logic watchdog_reset_req, vector_req, halt_exec, instr_busy;
  logic isr_enter, isr_return, global_irq_enable;
  int miscompares = 0;
  int checks_done = 0;
  int vec_cnt = 0;
  int wdc_cnt = 0;
  logic [31:0] r;
  int n;

  // 10 MHz clock
  always #50 pclk = ~pclk;

  // Vector requests and watchdog clears seen so far
  always @(posedge pclk)
  begin
    vec_cnt <= vec_cnt + int'(vector_req === 1'b1);
    wdc_cnt <= wdc_cnt + int'(watchdog_clear === 1'b1);
  end

  pmc_power_mode_controller pmc_power_mode_controller_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr(), .halt_exec, .halt_pc, .instr_busy, .isr_enter, .isr_return,
    .global_irq_enable, .irq_flags, .peripheral_irq_enable(irq_en),
    .clk_switch_irq_mask(8'h01), .program_memory_ready(mem_rdy), .sys_clock_ready(1'b1),
    .brownout_ready(1'b1), .watchdog_expired(wdx), .cpu_cycle_en, .periph_clk_en,
    .osc_run_en, .port_hold, .watchdog_clear, .watchdog_run, .watchdog_reset_req,
    .vector_req, .fetch_addr, .power_down_flag, .timeout_flag);

  pmc_core_model pmc_core_model_inst (
    .pclk, .vector_req, .halt_exec, .halt_pc, .instr_busy, .isr_enter, .isr_return,
    .global_irq_enable);

  //////////////////////////////////////////////////////////////////////
  // Verdict, reached by the main sequence or a timeout
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50)
    begin
      miscompares++;
      give_verdict();
    end
  endtask : apb

  // Cycles until the controller is back in run
  task automatic wait_run();
    n = 0;
    while (port_hold !== 1'b0 && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000)
    begin
      miscompares++;
      give_verdict();
    end
    repeat (4) @(posedge pclk);
  endtask : wait_run

  //////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    apb(1'b0, PMC_CTRL_OFS, 0);
    chk(r, 32'h0000_0000, "ctrl rst");
    apb(1'b0, PMC_STAT_OFS, 0);
    chk(r, 32'h0000_0003, "stat rst");
    chk({power_down_flag, timeout_flag, osc_run_en, watchdog_run}, 4'hf, "flag rst");
    apb(1'b0, 12'h00c, 0);
    chk(r, 32'h0000_0000, "unmapped");
    $display("reset test done");
  endtask : t_reset

  // Every ratio code over 256 cycles; peripherals never skip
  task automatic t_ratio();
    int c;
    int p;
    for (int code = 0; code < 8; code++)
    begin
      apb(1'b1, PMC_CTRL_OFS, 32'h40 | code);
      c = 0;
      p = 0;
      repeat (256)
      begin
        @(posedge pclk);
        c += int'(cpu_cycle_en === 1'b1);
        p += int'(periph_clk_en === 1'b1);
      end
      chk(c, 256 >> (code + 1), "cpu cycles");
      chk(p, 256, "periph cycles");
    end
    apb(1'b1, PMC_CTRL_OFS, 0);
    $display("ratio test done");
  endtask : t_ratio

  task automatic t_sleep();
    int w;
    w = wdc_cnt;
    pmc_core_model_inst.halt(16'h0100);
    @(negedge pclk);
    chk(fetch_addr, 16'h0102, "prefetch");
    chk({cpu_cycle_en, periph_clk_en}, 2'b00, "sleep clocks");
    apb(1'b0, PMC_STAT_OFS, 0);
    chk(r, {25'h0, PMC_SLEEP, 4'h2}, "sleep stat");
    chk({watchdog_run, osc_run_en, power_down_flag, timeout_flag}, 4'h5, "sleep outs");
    irq_flags <= 8'h05;
    mem_rdy <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(port_hold, 1'b1, "clk switch woke");
    irq_flags <= 8'h07;
    repeat (20) @(posedge pclk);
    chk(port_hold, 1'b1, "woke before ready");
    mem_rdy <= 1'b1;
    wait_run();
    chk(vec_cnt, 0, "vector without gie");
    chk(wdc_cnt - w, 2, "watchdog clears");
    w = wdc_cnt;
    pmc_core_model_inst.halt(16'h0200);
    apb(1'b0, PMC_STAT_OFS, 0);
    chk(r, {25'h0, PMC_RUN, 4'h2}, "noop stat");
    chk(wdc_cnt - w, 0, "noop clear");
    irq_flags <= 8'h00;
    $display("sleep test done");
  endtask : t_sleep

  task automatic t_idle();
    apb(1'b1, PMC_CTRL_OFS, 32'ha0);
    pmc_core_model_inst.global_irq_enable <= 1'b1;
    pmc_core_model_inst.halt(16'h0300);
    apb(1'b1, PMC_CTRL_OFS, 32'he0);
    chk({cpu_cycle_en, periph_clk_en}, 2'b01, "idle clocks");
    irq_flags <= 8'h02;
    pmc_core_model_inst.instr_busy <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(vec_cnt, 0, "vector in busy");
    pmc_core_model_inst.instr_busy <= 1'b0;
    wait_run();
    irq_flags <= 8'h00;
    pmc_core_model_inst.global_irq_enable <= 1'b0;
    chk(vec_cnt, 1, "idle vector");
    apb(1'b0, PMC_CTRL_OFS, 0);
    chk(r, 32'h0000_00a0, "roi clear");
    apb(1'b1, PMC_CTRL_OFS, 32'hb0);
    pmc_core_model_inst.ret();
    apb(1'b0, PMC_CTRL_OFS, 0);
    chk(r, 32'h0000_00f0, "rethrottle");
    apb(1'b1, PMC_CTRL_OFS, 32'hb0);
    pmc_core_model_inst.halt(16'h0400);
    apb(1'b1, PMC_CTRL_OFS, 32'hf0);
    apb(1'b0, PMC_STAT_OFS, 0);
    chk(r[6:4], PMC_IDLE, "idle again");
    wdx <= 1'b1;
    @(negedge pclk);
    chk(watchdog_reset_req, 1'b0, "wd reset in idle");
    @(posedge pclk);
    wdx <= 1'b0;
    wait_run();
    apb(1'b0, PMC_CTRL_OFS, 0);
    chk(r, 32'h0000_00f0, "wd wake ctrl");
    apb(1'b1, PMC_CTRL_OFS, 0);
    $display("idle test done");
  endtask : t_idle

  task automatic t_xtal();
    apb(1'b1, PMC_CFG_OFS, 32'h5);
    pmc_core_model_inst.halt(16'h0500);
    @(negedge pclk);
    chk(watchdog_run, 1'b1, "wd runs in sleep");
    @(posedge pclk);
    irq_flags <= 8'h02;
    @(posedge pclk);
    wait_run();
    chk(n >= PMC_OST_PERIODS + 1 && n <= PMC_OST_PERIODS + 3, 1'b1, "start delay");
    irq_flags <= 8'h00;
    $display("crystal test done");
  endtask : t_xtal

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ratio();
    t_sleep();
    t_idle();
    t_xtal();
    give_verdict();
  end
endmodule : tb
